//--- logic/drc_ctrl.sv
// host-side controller: init, refresh scheduling and nibble accesses on the dram pins
`timescale 1ns/1ps
// Notes on behaviour
// - host refreshes all 256 rows within each 4 ms
// - column strobe high at row fall refreshes the addressed row
// - each column strobe toggle advances the low two column bits
// - after power-up wait 500 us then issue eight cycles
// - row strobe idle over 4 ms needs eight reinitialisation cycles
// - row latched on row fall, column on column fall, row rise ends
// - read holds write enable high while both strobes low
module drc_ctrl
  import drc_pkg::*;
#(
  parameter int POWERUP_CYC = POWERUP_WAIT_CYC,
  parameter int REFRESH_CYC = REFRESH_INTERVAL_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request side
  input wire logic reqValid,
  input wire drc_req_s req,
  output logic reqReady,
  output logic rdValid,
  output logic rdData,
  output logic initDone,
  // dram pins
  output drc_pins_s pins,
  input wire logic dout
);
  // power-up and refresh counters are 16 bits wide; longer spans would silently wrap early
  if (POWERUP_CYC < 1 || POWERUP_CYC > 65536) begin : gBadPowerup
    $error("drc_ctrl: power-up wait out of range");
  end
  if (REFRESH_CYC < 16 || REFRESH_CYC > 65536) begin : gBadRefresh
    $error("drc_ctrl: refresh interval out of range");
  end

  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_ROW, ST_COL, ST_COLHI, ST_CBR, ST_PRECH
  } drc_state_e;

  drc_state_e state_ff;
  logic [15:0] powerCnt_ff;
  logic [15:0] refCnt_ff;
  logic [3:0] initCnt_ff;
  logic [3:0] tCnt_ff;
  logic refPend_ff;
  logic [1:0] left_ff;
  drc_req_s cur_ff;
  drc_pins_s pins_ff;
  logic reqReady_ff;
  logic rdValid_ff;
  logic rdData_ff;
  logic initDone_ff;

  assign pins = pins_ff;
  assign reqReady = reqReady_ff;
  assign rdValid = rdValid_ff;
  assign rdData = rdData_ff;
  assign initDone = initDone_ff;

  // refresh tick: one row per interval keeps 256 rows inside 4 ms; also keeps
  // the row strobe from idling long enough to need reinitialisation
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      refCnt_ff <= '0;
      refPend_ff <= 1'b0;
    end else begin
      if (refCnt_ff == 16'(REFRESH_CYC - 1)) begin
        refCnt_ff <= '0;
        refPend_ff <= 1'b1;
      end else begin
        refCnt_ff <= refCnt_ff + 16'h0001;
        // a tick that lands on the clear leaves the request standing
        if (state_ff == ST_CBR && tCnt_ff == 4'h0) refPend_ff <= 1'b0;
      end
    end
  end

  // power-up pause; stops counting once the wait has elapsed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      powerCnt_ff <= '0;
    end else if (state_ff == ST_POWERUP && powerCnt_ff != 16'(POWERUP_CYC - 1)) begin
      powerCnt_ff <= powerCnt_ff + 16'h0001;
    end
  end

  // counts the initialisation cycles issued before normal operation
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      initCnt_ff <= '0;
    end else if (state_ff == ST_CBR && tCnt_ff == 4'(STROBE_CYC + 1) && !initDone_ff) begin
      initCnt_ff <= initCnt_ff + 4'h1;
    end
  end

  // read data is taken on the edge that raises the column strobe, while it still stands
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdValid_ff <= 1'b0;
      rdData_ff <= 1'b0;
    end else if (state_ff == ST_COL && tCnt_ff == 4'(STROBE_CYC - 1)) begin
      rdValid_ff <= ~cur_ff.write;
      rdData_ff <= dout;
    end else begin
      rdValid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_POWERUP;
      tCnt_ff <= '0;
      left_ff <= '0;
      cur_ff <= '0;
      pins_ff <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, addr: 8'h00, din: 1'b0};
      reqReady_ff <= 1'b0;
      initDone_ff <= 1'b0;
    end else begin
      reqReady_ff <= 1'b0;
      case (state_ff)
        ST_POWERUP: begin
          if (powerCnt_ff == 16'(POWERUP_CYC - 1)) begin
            state_ff <= ST_CBR;
            tCnt_ff <= 4'h0;
          end
        end
        ST_IDLE: begin
          // a request offered under ready is honoured first; the pending refresh
          // waits one access at most, which the shortened interval absorbs
          if (reqValid && reqReady_ff) begin
            cur_ff <= req;
            left_ff <= req.count;
            pins_ff.addr <= req.row;
            pins_ff.rasN <= 1'b0;
            state_ff <= ST_ROW;
            tCnt_ff <= 4'h0;
          end else if (refPend_ff) begin
            // column strobe first, then row strobe: device uses its own counter
            pins_ff.casN <= 1'b0;
            state_ff <= ST_CBR;
            tCnt_ff <= 4'h0;
          end else begin
            reqReady_ff <= initDone_ff;
          end
        end
        ST_ROW: begin
          tCnt_ff <= tCnt_ff + 4'h1;
          if (tCnt_ff == 4'h1) pins_ff.addr <= cur_ff.col;
          if (tCnt_ff == 4'h2) begin
            // write enable before column fall gives an early write
            pins_ff.weN <= ~cur_ff.write;
            pins_ff.din <= cur_ff.din;
          end
          if (tCnt_ff == 4'h3) begin
            pins_ff.casN <= 1'b0;
            state_ff <= ST_COL;
            tCnt_ff <= 4'h0;
          end
        end
        ST_COL: begin
          tCnt_ff <= tCnt_ff + 4'h1;
          if (tCnt_ff == 4'(STROBE_CYC - 1)) begin
            pins_ff.casN <= 1'b1;
            tCnt_ff <= 4'h0;
            if (left_ff != 2'b00) begin
              // write enable stays as set, so every bit of a write burst is written
              left_ff <= left_ff - 2'b01;
              state_ff <= ST_COLHI;
            end else begin
              pins_ff.rasN <= 1'b1;
              pins_ff.weN <= 1'b1;
              state_ff <= ST_PRECH;
            end
          end
        end
        ST_COLHI: begin
          // device increments its low column bits and wraps after four
          pins_ff.casN <= 1'b0;
          state_ff <= ST_COL;
        end
        ST_CBR: begin
          tCnt_ff <= tCnt_ff + 4'h1;
          if (tCnt_ff == 4'h0) pins_ff.casN <= 1'b0;
          if (tCnt_ff == 4'h1) pins_ff.rasN <= 1'b0;
          if (tCnt_ff == 4'(STROBE_CYC + 1)) begin
            pins_ff.rasN <= 1'b1;
            pins_ff.casN <= 1'b1;
            state_ff <= ST_PRECH;
            tCnt_ff <= 4'h0;
          end
        end
        ST_PRECH: begin
          tCnt_ff <= tCnt_ff + 4'h1;
          if (tCnt_ff == 4'(PRECHARGE_CYC - 1)) begin
            tCnt_ff <= 4'h0;
            if (!initDone_ff && initCnt_ff != 4'(INIT_CYCLES)) begin
              state_ff <= ST_CBR;
            end else begin
              initDone_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- logic/drc_pkg.sv
// constants and carrier types for the dram refresh and nibble controller
package drc_pkg;
  localparam int CLK_NS = 25;
  localparam int ROW_COUNT = 256;
  localparam int REFRESH_PERIOD_MS = 4;
  localparam int POWERUP_WAIT_US = 500;
  localparam int INIT_CYCLES = 8;
  // one cycle short of the even split: a refresh deferred behind a burst still lands in time
  localparam int REFRESH_INTERVAL_CYC = (REFRESH_PERIOD_MS * 1000000) / (ROW_COUNT * CLK_NS) - 1;
  localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = 4;
  localparam int PRECHARGE_CYC = 3;
  localparam int NIBBLE_LEN = 4;

  typedef struct packed {
    logic [7:0] row;
    logic [7:0] col;
    logic write;
    logic din;
    logic [1:0] count;
  } drc_req_s;

  typedef struct packed {
    logic rasN;
    logic casN;
    logic weN;
    logic [7:0] addr;
    logic din;
  } drc_pins_s;
endpackage

//--- sim/drc_ctrl_chk.sv
// port assertions for the dram controller
`timescale 1ns/1ps
module drc_ctrl_chk
  import drc_pkg::*;
#(parameter int REFRESH_CYC = 16) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request side
  input wire logic reqValid,
  input wire drc_req_s req,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic rdData,
  input wire logic initDone,
  // dram pins
  input wire drc_pins_s pins,
  input wire logic dout
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  int gap;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) gap <= 0;
    else gap <= pins.rasN ? gap + 1 : 0;
  end
  take_row_a: assert property (reqValid && reqReady |-> ##[1:3] ($fell(pins.rasN) && pins.casN)) else $error("no row strobe");
  busy_ready_a: assert property (!pins.rasN |-> !reqReady) else $error("ready in cycle");
  ready_init_a: assert property (reqReady |-> initDone) else $error("ready early");
  init_cbr_a: assert property ($fell(pins.rasN) && !initDone |-> !pins.casN) else $error("init");
  read_we_a: assert property (rdValid |-> pins.weN) else $error("read we");
  rd_data_a: assert property (rdValid |-> rdData == $past(dout)) else $error("rd data");
  precharge_a: assert property ($rose(pins.rasN) |-> pins.rasN [*3]) else $error("prech");
  refresh_gap_a: assert property (initDone |-> gap < REFRESH_CYC + 64) else $error("gap");
  cover property ($fell(pins.rasN) && !pins.casN);
  cover property (rdValid ##5 rdValid);
  cover property (reqValid && reqReady && req.write);
endmodule
bind drc_ctrl drc_ctrl_chk #(.REFRESH_CYC(REFRESH_CYC)) drc_ctrl_chk_inst (.clk_sys(clk_sys),
  .nrst(nrst), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdValid(rdValid),
  .rdData(rdData), .initDone(initDone), .pins(pins), .dout(dout));

//--- sim/drc_dram_model.sv
// behavioural model of the 64k x 1 dram on the controller pins
`timescale 1ns/1ps
module drc_dram_model
  import drc_pkg::*;
(
  // pins from controller
  input wire drc_pins_s pins,
  // data back
  output logic dout
);
  logic mem [0:65535];
  logic [7:0] row, col, ctr = 8'h00;
  logic sel = 1'h0, first, drv = 1'h0, q;
  always @(negedge pins.rasN) begin
    if (pins.casN) begin
      row = pins.addr;
      sel = 1'h1;
      first = 1'h1;
    end else ctr = ctr + 8'h01;
  end
  always @(posedge pins.rasN) sel = 1'h0;
  // strobe without overlap never selects
  always @(negedge pins.casN) if (sel) begin
    col = first ? pins.addr : {col[7:2], col[1:0] + 2'h1};
    first = 1'h0;
    q = mem[{row, col}];
    drv = pins.weN;
    if (!pins.weN) mem[{row, col}] = pins.din;
  end
  always @(negedge pins.weN) if (sel && !pins.casN) mem[{row, col}] = pins.din;
  always @(posedge pins.casN) drv = 1'h0;
  // released line shows the inverse so a stale value cannot pass
  assign dout = drv ? q : !q;
endmodule

//--- sim/tb.sv
// self-checking bench for the dram controller
`timescale 1ns/1ps
module tb;
  import drc_pkg::*;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic reqValid = 1'h0;
  drc_req_s req = '0;
  logic reqReady, rdValid, rdData, initDone, dout;
  drc_pins_s pins;
  int err_count = 0;
  int total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  drc_ctrl #(.POWERUP_CYC(20), .REFRESH_CYC(200)) drc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
    .initDone(initDone), .pins(pins), .dout(dout));
  drc_dram_model drc_dram_model_inst (.pins(pins), .dout(dout));
  task automatic conclude();
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  // ready is registered, so high at a falling edge means taken at the next rise
  task automatic issue(input logic [7:0] r, c, input logic w, d, input logic [1:0] n);
    for (int i = 0; i < 500 && reqReady !== 1'h1; i++) @(negedge clk_sys);
    chk(reqReady, 1'h1);
    req = '{r, c, w, d, n};
    reqValid = 1'h1;
    @(negedge clk_sys);
    reqValid = 1'h0;
  endtask
  task automatic rd(input logic [7:0] r, c, input logic [3:0] e);
    issue(r, c, 1'h0, 1'h0, 2'h3);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 50 && rdValid !== 1'h1; i++) @(negedge clk_sys);
      chk(rdValid, 1'h1);
      chk(rdData, e[k]);
      @(negedge clk_sys);
    end
  endtask
  task automatic sc_nibble();
    issue(8'haa, 8'ha8, 1'h1, 1'h0, 2'h3);
    issue(8'h55, 8'ha8, 1'h1, 1'h0, 2'h3);
    issue(8'haa, 8'haa, 1'h1, 1'h1, 2'h0);
    issue(8'h55, 8'ha8, 1'h1, 1'h1, 2'h0);
    rd(8'haa, 8'ha9, 4'h2);
    rd(8'h55, 8'hab, 4'h2);
  endtask
  // idle long enough for several refresh rounds, then data must survive
  task automatic sc_refresh();
    repeat (700) @(negedge clk_sys);
    rd(8'haa, 8'haa, 4'h1);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    nrst = 1'h1;
    for (int i = 0; i < 2000 && initDone !== 1'h1; i++) @(negedge clk_sys);
    chk(initDone, 1'h1);
    sc_nibble();
    sc_refresh();
    conclude();
  end
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
endmodule
